/* hdl/gig_ms_pkg.sv */
// Purpose: constants and carriers for the gigabit master/slave register bank
// Assumes: word-indexed registers, byte address = 4 * index
// Notes: classic wishbone slave, 32-bit data, 16-bit registers in the low half
package gig_ms_pkg;
	localparam int          ADR_W        = 8;
	// register indices
	localparam logic [5:0]  IDX_CTRL     = 6'h09;
	localparam logic [5:0]  IDX_STS      = 6'h0a;
	localparam logic [5:0]  IDX_RSV_LO   = 6'h0b;
	localparam logic [5:0]  IDX_RSV_HI   = 6'h0e;
	localparam logic [5:0]  IDX_IRQ_STS  = 6'h18;
	localparam logic [5:0]  IDX_IRQ_MASK = 6'h19;
	// control field positions
	localparam int          CTL_TM_HI    = 15;
	localparam int          CTL_TM_LO    = 13;
	localparam int          CTL_MAN_EN   = 12;
	localparam int          CTL_MAN_ROLE = 11;
	localparam int          CTL_PORT     = 10;
	localparam int          CTL_ADV_FD   = 9;
	localparam int          CTL_ADV_HD   = 8;
	// status field positions
	localparam int          STS_FAULT    = 15;
	localparam int          STS_ROLE     = 14;
	localparam int          STS_LOC_OK   = 13;
	localparam int          STS_REM_OK   = 12;
	localparam int          STS_LP_FD    = 11;
	localparam int          STS_LP_HD    = 10;
	localparam int          STS_LP_ASYM  = 9;
	localparam int          STS_RSV      = 8;
	// test mode codes
	localparam logic [2:0]  TM_NORMAL    = 3'h0;
	localparam logic [2:0]  TM_1         = 3'h1;
	localparam logic [2:0]  TM_2         = 3'h2;
	localparam logic [2:0]  TM_3         = 3'h3;
	localparam logic [2:0]  TM_4         = 3'h4;
	localparam logic [2:0]  TM_RST       = 3'h0;
	localparam logic [7:0]  IDLE_CNT_RST = 8'h00;
	localparam logic [7:0]  IDLE_CNT_MAX = 8'hff;
	// interrupt bits
	localparam int          IRQ_N        = 3;
	localparam int          IRQ_FAULT    = 0;
	localparam int          IRQ_LOC      = 1;
	localparam int          IRQ_REM      = 2;
	localparam logic [2:0]  IRQ_RST      = 3'h0;
	localparam int          STRAP_N      = 5;

	typedef struct packed {
		logic manual_en;
		logic manual_role;
		logic port_multi;
		logic adv_fd;
		logic adv_hd;
	} strap_s;

	typedef struct packed {
		logic ms_fault;
		logic resolved_role;
		logic local_rx_ok;
		logic remote_rx_ok;
		logic partner_gig_full_duplex;
		logic partner_gig_half_duplex;
		logic partner_asym_pause;
	} link_stat_s;

	typedef struct packed {
		logic [2:0] test_mode;
		logic       manual_en;
		logic       manual_role;
		logic       port_multi;
		logic       adv_fd;
		logic       adv_hd;
	} ctrl_s;
endpackage

/* hdl/gigabit_ms_ctrl_status_regs.sv */
// Purpose: gigabit master/slave control and status registers
// Assumes: link status and idle errors come from logic on clk_i
// Notes: straps are pins and pass a three-stage synchroniser
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module gigabit_ms_ctrl_status_regs
(
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// wishbone slave
	input  wire logic                     cyc_i,
	input  wire logic                     stb_i,
	input  wire logic                     we_i,
	input  wire logic [gig_ms_pkg::ADR_W-1:0] adr_i,
	input  wire logic [3:0]               sel_i,
	input  wire logic [31:0]              dat_i,
	output logic      [31:0]              dat_o,
	output logic                          ack_o,
	// strap pins
	input  wire gig_ms_pkg::strap_s       strap_i,
	// link status from the receive side
	input  wire gig_ms_pkg::link_stat_s   link_i,
	input  wire logic                     idle_err_i,
	// control outputs
	output gig_ms_pkg::ctrl_s             ctrl_o,
	output logic                          irq_o
);
	import gig_ms_pkg::*;

	logic   [STRAP_N-1:0] s1_r;
	logic   [STRAP_N-1:0] s2_r;
	logic   [STRAP_N-1:0] s3_r;
	logic   [STRAP_N-1:0] strap_filt_r;
	ctrl_s                ctrl_r;
	logic   [7:0]         idle_cnt_r;
	logic   [7:0]         idle_cnt_nxt;
	logic   [IRQ_N-1:0]   irq_sts_r;
	logic   [IRQ_N-1:0]   irq_mask_r;
	logic   [IRQ_N-1:0]   irq_ev;
	link_stat_s           link_prev_r;
	logic                 ack_r;
	logic   [31:0]        dat_r;
	logic   [31:0]        rdata;
	logic   [15:0]        sts_word;
	logic   [5:0]         idx;
	logic                 take;
	logic                 wr;
	logic                 rd_sts;
	strap_s               strap_v;

	assign idx     = adr_i[ADR_W-1:2];
	// one cycle per access; ack falls the cycle after it rose
	assign take    = cyc_i & stb_i & ~ack_r;
	assign wr      = take & we_i;
	assign rd_sts  = take & ~we_i & (idx == IDX_STS);
	assign ack_o   = ack_r;
	assign dat_o   = dat_r;
	assign ctrl_o  = ctrl_r;
	assign strap_v = strap_filt_r;

	genvar g;
	generate
		for (g = 0; g < STRAP_N; g++) begin : g_strap
			always_ff @(posedge clk_i) begin
				s1_r[g] <= strap_i[g];
				s2_r[g] <= s1_r[g];
				s3_r[g] <= s2_r[g];
				if (s2_r[g] == s3_r[g]) begin
					strap_filt_r[g] <= s3_r[g];
				end
			end
		end
	endgenerate

	// control register; straps keep loading while reset is held
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r.test_mode   <= TM_RST;
			ctrl_r.manual_en   <= strap_v.manual_en;
			ctrl_r.manual_role <= strap_v.manual_role;
			ctrl_r.port_multi  <= strap_v.port_multi;
			ctrl_r.adv_fd      <= strap_v.adv_fd;
			ctrl_r.adv_hd      <= strap_v.adv_hd;
		end else if (wr && idx == IDX_CTRL && sel_i[1]) begin
			ctrl_r.test_mode   <= dat_i[CTL_TM_HI:CTL_TM_LO];
			ctrl_r.manual_en   <= dat_i[CTL_MAN_EN];
			ctrl_r.manual_role <= dat_i[CTL_MAN_ROLE];
			ctrl_r.adv_fd      <= dat_i[CTL_ADV_FD];
			ctrl_r.adv_hd      <= dat_i[CTL_ADV_HD];
		end
	end

	always_comb begin
		idle_cnt_nxt = idle_cnt_r;
		if (rd_sts) begin
			idle_cnt_nxt = IDLE_CNT_RST;
		end
		if (idle_err_i && idle_cnt_nxt != IDLE_CNT_MAX) begin
			idle_cnt_nxt = idle_cnt_nxt + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_cnt_r <= IDLE_CNT_RST;
		end else begin
			idle_cnt_r <= idle_cnt_nxt;
		end
	end

	// status word
	always_comb begin
		sts_word = 16'h0000;
		sts_word[STS_FAULT]   = link_i.ms_fault;
		sts_word[STS_ROLE]    = link_i.resolved_role & ~link_i.ms_fault;
		sts_word[STS_LOC_OK]  = link_i.local_rx_ok;
		sts_word[STS_REM_OK]  = link_i.remote_rx_ok;
		sts_word[STS_LP_FD]   = link_i.partner_gig_full_duplex;
		sts_word[STS_LP_HD]   = link_i.partner_gig_half_duplex;
		sts_word[STS_LP_ASYM] = link_i.partner_asym_pause;
		sts_word[STS_RSV]     = 1'b0;
		sts_word[7:0]         = idle_cnt_r;
	end

	// read mux; unmapped and reserved indices read zero
	always_comb begin
		rdata = 32'h0000_0000;
		case (idx)
			IDX_CTRL: begin
				rdata[CTL_TM_HI:CTL_TM_LO] = ctrl_r.test_mode;
				rdata[CTL_MAN_EN]          = ctrl_r.manual_en;
				rdata[CTL_MAN_ROLE]        = ctrl_r.manual_role;
				rdata[CTL_PORT]            = ctrl_r.port_multi;
				rdata[CTL_ADV_FD]          = ctrl_r.adv_fd;
				rdata[CTL_ADV_HD]          = ctrl_r.adv_hd;
			end
			IDX_STS: begin
				rdata[15:0] = sts_word;
			end
			IDX_IRQ_STS: begin
				rdata[IRQ_N-1:0] = irq_sts_r;
			end
			IDX_IRQ_MASK: begin
				rdata[IRQ_N-1:0] = irq_mask_r;
			end
			default: begin
				rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= take;
			if (take && !we_i) begin
				dat_r <= rdata;
			end
		end
	end

	// interrupt events from link status edges
	assign irq_ev[IRQ_FAULT] = link_i.ms_fault & ~link_prev_r.ms_fault;
	assign irq_ev[IRQ_LOC]   = link_i.local_rx_ok ^ link_prev_r.local_rx_ok;
	assign irq_ev[IRQ_REM]   = link_i.remote_rx_ok ^ link_prev_r.remote_rx_ok;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_prev_r <= '0;
		end else begin
			link_prev_r <= link_i;
		end
	end

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_sts_r <= IRQ_RST;
		end else if (wr && idx == IDX_IRQ_STS && sel_i[0]) begin
			irq_sts_r <= (irq_sts_r & ~dat_i[IRQ_N-1:0]) | irq_ev;
		end else begin
			irq_sts_r <= irq_sts_r | irq_ev;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_r <= IRQ_RST;
		end else if (wr && idx == IDX_IRQ_MASK && sel_i[0]) begin
			irq_mask_r <= dat_i[IRQ_N-1:0];
		end
	end

	assign irq_o = |(irq_sts_r & irq_mask_r);

	// checks
	logic ctl_wr;
	assign ctl_wr = wr && idx == IDX_CTRL && sel_i[1];

	property p_tm_wr;
		@(posedge clk_i) disable iff (rst_i)
		ctl_wr |=> ctrl_o.test_mode == $past(dat_i[CTL_TM_HI:CTL_TM_LO]);
	endproperty
	a_tm_wr: assert property (p_tm_wr) else $error("test mode write lost");

	property p_man_en;
		@(posedge clk_i) disable iff (rst_i)
		ctl_wr ##1 !ctl_wr[*2] |-> ctrl_o.manual_en == $past(dat_i[CTL_MAN_EN], 2);
	endproperty
	a_man_en: assert property (p_man_en) else $error("manual enable not held");

	property p_man_role;
		@(posedge clk_i) disable iff (rst_i)
		ctl_wr |=> ctrl_o.manual_role == $past(dat_i[CTL_MAN_ROLE]);
	endproperty
	a_man_role: assert property (p_man_role) else $error("manual role write lost");

	property p_strap;
		@(posedge clk_i)
		rst_i && $past(s2_r == s3_r) |=> ctrl_o[4:0] == $past(strap_filt_r);
	endproperty
	a_strap: assert property (p_strap) else $error("strap not loaded in reset");

	property p_port_ro;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> $stable(ctrl_o.port_multi);
	endproperty
	a_port_ro: assert property (p_port_ro) else $error("port type changed");

	property p_adv;
		@(posedge clk_i) disable iff (rst_i)
		ctl_wr |=> {ctrl_o.adv_fd, ctrl_o.adv_hd} == $past(dat_i[CTL_ADV_FD:CTL_ADV_HD]);
	endproperty
	a_adv: assert property (p_adv) else $error("duplex advert write lost");

	property p_sts_rd;
		@(posedge clk_i) disable iff (rst_i)
		rd_sts |=> ack_o && dat_o[STS_FAULT] == $past(link_i.ms_fault)
			&& dat_o[STS_LP_FD] == $past(link_i.partner_gig_full_duplex)
			&& dat_o[STS_RSV] == 1'b0;
	endproperty
	a_sts_rd: assert property (p_sts_rd) else $error("status read wrong");

	property p_role;
		@(posedge clk_i) disable iff (rst_i)
		rd_sts && link_i.ms_fault |=> dat_o[STS_ROLE] == 1'b0;
	endproperty
	a_role: assert property (p_role) else $error("role shown under fault");

	property p_rsv;
		@(posedge clk_i) disable iff (rst_i)
		take && !we_i && idx >= IDX_RSV_LO && idx <= IDX_RSV_HI |=> ack_o && dat_o == 32'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved read not zero");

	property p_sat;
		@(posedge clk_i) disable iff (rst_i)
		idle_cnt_r == IDLE_CNT_MAX && !rd_sts |=> idle_cnt_r == IDLE_CNT_MAX;
	endproperty
	a_sat: assert property (p_sat) else $error("idle count wrapped");

	property p_clr;
		@(posedge clk_i) disable iff (rst_i)
		rd_sts && !idle_err_i |=> idle_cnt_r == 8'h00 ##1 !ack_o;
	endproperty
	a_clr: assert property (p_clr) else $error("idle count not cleared");

	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
		(irq_ev & irq_mask_r) != 3'h0 && !(wr && idx == IDX_IRQ_MASK) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missed");

	property p_tm_rst;
		@(posedge clk_i)
		rst_i |=> ctrl_o.test_mode == TM_RST;
	endproperty
	a_tm_rst: assert property (p_tm_rst) else $error("test mode not reset");

	property p_sts_self;
		@(posedge clk_i) disable iff (rst_i)
		rd_sts && !link_i.ms_fault |=> dat_o[STS_ROLE] == $past(link_i.resolved_role)
			&& dat_o[STS_LOC_OK] == $past(link_i.local_rx_ok)
			&& dat_o[STS_REM_OK] == $past(link_i.remote_rx_ok);
	endproperty
	a_sts_self: assert property (p_sts_self) else $error("own status wrong");

	property p_sts_lp;
		@(posedge clk_i) disable iff (rst_i)
		rd_sts |=> dat_o[STS_LP_HD] == $past(link_i.partner_gig_half_duplex)
			&& dat_o[STS_LP_ASYM] == $past(link_i.partner_asym_pause);
	endproperty
	a_sts_lp: assert property (p_sts_lp) else $error("partner ability wrong");

	property p_cnt_inc;
		@(posedge clk_i) disable iff (rst_i)
		idle_err_i && !rd_sts && idle_cnt_r != IDLE_CNT_MAX
			|=> idle_cnt_r == $past(idle_cnt_r) + 8'h01;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("idle error not counted");

	// one wait state, then ack drops so a held strobe is not taken twice
	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		take |=> ack_o ##1 !ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse");

	c_ctl_wr: cover property (@(posedge clk_i) disable iff (rst_i) ctl_wr);
	c_sat: cover property (@(posedge clk_i) disable iff (rst_i) idle_cnt_r == IDLE_CNT_MAX);
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
	c_sts_flt: cover property (@(posedge clk_i) disable iff (rst_i) rd_sts && link_i.ms_fault);
	c_rsv: cover property (@(posedge clk_i) disable iff (rst_i) wr && idx == IDX_RSV_LO);
endmodule
`default_nettype wire

/* dv/link_side_model.sv */
// Purpose: far-side stand-in driving link status and idle error pulses
// Assumes: same clock as the register block
// Notes: slow mode spaces the error pulses one idle cycle apart
`timescale 1ns/1ps
`default_nettype none
module link_side_model
(
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// commands from the bench
	input  wire gig_ms_pkg::link_stat_s want_i,
	input  wire logic [8:0]             burst_i,
	input  wire logic                   go_i,
	input  wire logic                   slow_i,
	// towards the register block
	output var gig_ms_pkg::link_stat_s  link_o,
	output logic                        idle_err_o,
	output logic                        busy_o
);
	import gig_ms_pkg::*;

	logic [8:0] left_r;
	logic       ph_r;
	// levels registered, as real receive logic would present them
	always_ff @(posedge clk_i) begin
		if (rst_i)
			link_o <= '0;
		else
			link_o <= want_i;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left_r <= 9'h000;
			ph_r <= 1'b0;
		end else begin
			ph_r <= ~ph_r;
			if (go_i)
				left_r <= burst_i;
			else if (idle_err_o)
				left_r <= left_r - 9'h001;
		end
	end
	assign idle_err_o = (left_r != 9'h000) && (ph_r || !slow_i);
	assign busy_o = (left_r != 9'h000);
endmodule
`default_nettype wire

/* dv/gigabit_ms_ctrl_status_regs_tb.sv */
// Purpose: self-checking bench for the gigabit master/slave registers
// Assumes: one clock, bench drives just after rising edges
// Notes: expectations come from a small integer model of the bank
`timescale 1ns/1ps
`default_nettype none
module gigabit_ms_ctrl_status_regs_tb;
	import gig_ms_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o, irq_o, idle_err, busy;
	logic        go = 1'b0;
	logic        slow = 1'b0;
	logic [8:0]  burst = 9'h000;
	strap_s      strap_i;
	link_stat_s  want = '0;
	link_stat_s  link, v;
	ctrl_s       ctrl_o;
	logic [15:0] q, d, e;
	int          failures = 0;
	int          cmp_count = 0;
	int          cnt = 0;
	int          ist = 0;
	int          msk = 0;

	gigabit_ms_ctrl_status_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .strap_i(strap_i), .link_i(link),
		.idle_err_i(idle_err), .ctrl_o(ctrl_o), .irq_o(irq_o));
	link_side_model u_far (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .burst_i(burst),
		.go_i(go), .slow_i(slow), .link_o(link), .idle_err_o(idle_err), .busy_o(busy));

	initial forever #25 clk_i = ~clk_i;

	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// one classic cycle; a status read clears the model's count
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {16'h0000, wd};
		sel_i <= 4'($urandom) | 4'h3;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			give_verdict();
		end
		q = dat_o[15:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (!w && a == 8'h28)
			cnt = 0;
	endtask

	task automatic setl(input link_stat_s s);
		ist |= {s.remote_rx_ok != want.remote_rx_ok, s.local_rx_ok != want.local_rx_ok,
			s.ms_fault & ~want.ms_fault};
		@(posedge clk_i);
		want <= s;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic errs(input int n, input logic s);
		int k;
		k = 0;
		@(posedge clk_i);
		burst <= 9'(n);
		slow <= s;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		do begin
			@(posedge clk_i);
			k++;
		end while (busy !== 1'b0 && k < 2000);
		if (k >= 2000) begin
			failures++;
			give_verdict();
		end
		cnt = (cnt + n > 255) ? 255 : cnt + n;
	endtask

	// role reads zero while a fault stands
	function automatic logic [15:0] exp_sts();
		return {want[6], want[5] & ~want[6], want[4:0], 1'b0, 8'(cnt)};
	endfunction

	initial begin
		void'($urandom(32'he558));
		strap_i = 5'($urandom);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h24, 16'h0000);
		chk(q, {3'h0, strap_i, 8'h00});
		chk({8'h00, ctrl_o}, {8'h00, TM_RST, strap_i});
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			d = 16'($urandom);
			d[15:13] = 3'(i);
			e = {d[15:11], strap_i.port_multi, d[9:8], 8'h00};
			wb(1'b1, 8'h24, d);
			wb(1'b0, 8'h24, 16'h0000);
			chk(q, e);
			chk({8'h00, ctrl_o}, {8'h00, e[15:8]});
		end
		$display("test control done");
		for (int i = 0; i < 12; i++) begin
			setl(link_stat_s'(7'($urandom)));
			errs(i * 3, i[0]);
			wb(1'b1, 8'h28, 16'hffff);
			e = exp_sts();
			wb(1'b0, 8'h28, 16'h0000);
			chk(q, e);
		end
		errs(300, 1'b0);
		for (int i = 0; i < 2; i++) begin
			e = exp_sts();
			wb(1'b0, 8'h28, 16'h0000);
			chk(q, e);
		end
		$display("test status done");
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, (i < 4) ? 8'(8'h2c + 4 * i) : 8'hfc, 16'hffff);
			wb(1'b0, (i < 4) ? 8'(8'h2c + 4 * i) : 8'hfc, 16'h0000);
			chk(q, 16'h0000);
		end
		$display("test reserved done");
		wb(1'b1, 8'h64, 16'h0000);
		wb(1'b1, 8'h60, 16'h0007);
		ist = 0;
		v = want;
		v.ms_fault = 1'b0;
		setl(v);
		v.ms_fault = 1'b1;
		v.resolved_role = 1'b1;
		v.local_rx_ok = ~v.local_rx_ok;
		setl(v);
		e = exp_sts();
		wb(1'b0, 8'h28, 16'h0000);
		chk(q, e);
		wb(1'b0, 8'h60, 16'h0000);
		chk(q, 16'(ist));
		chk(16'(irq_o), 16'h0000);
		for (int m = 1; m < 8; m = m * 2) begin
			msk = m;
			wb(1'b1, 8'h64, 16'(m));
			chk(16'(irq_o), 16'((ist & msk) != 0));
		end
		wb(1'b1, 8'h60, 16'(ist));
		ist = 0;
		chk(16'(irq_o), 16'h0000);
		// an unmasked change must raise the line with no further access
		wb(1'b1, 8'h64, 16'h0007);
		v.remote_rx_ok = ~v.remote_rx_ok;
		setl(v);
		chk(16'(irq_o), 16'h0001);
		wb(1'b0, 8'h60, 16'h0000);
		chk(q, 16'(ist));
		$display("test interrupt done");
		// a second reset reloads changed straps and clears the count
		@(posedge clk_i);
		strap_i <= ~strap_i;
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		cnt = 0;
		wb(1'b0, 8'h24, 16'h0000);
		chk(q, {3'h0, strap_i, 8'h00});
		chk({8'h00, ctrl_o}, {8'h00, TM_RST, strap_i});
		e = exp_sts();
		wb(1'b0, 8'h28, 16'h0000);
		chk(q, e);
		$display("test second reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
